// [src/medet_pkg.sv]
// constants, register map and field layout of the motion event detectors
// Functional notes
// - orientation code: up/down bit, portrait/landscape pair
// - portrait/landscape switch with 0.66..1.66 hysteresis
// - up/down switch at 0g, hysteresis 0.4g
// - blocking setting 00 blocks nothing
// - settings 01-11 block on z, x+y, slope
// - slope block lifts after three quiet samples
// - blocking waits 100 ms stable before interrupt
// - swap bit makes x the up/down axis
// - orientation runs while enabled or in stand-alone mode
// - orientation interrupt lasts until the next sample
// - stand-alone mode drives orientation onto pins
// - status register holds code and triggered flag
// - freefall: all axes low for duration+1 samples
// - freefall threshold, hysteresis, duration fields, defaults
// - freefall enable and status flag
// - high-g: enabled axis high for duration+1 samples
// - high-g stores triggering axes and acceleration sign
// - high-g threshold, hysteresis, duration fields, defaults
// - per-axis high-g enables and status flag
// - data ready once all enabled axes updated
// - data ready mode masks other sources
// - data ready interrupt clears after 150 us
package medet_pkg;

    localparam int ACC_W = 8;
    localparam int ADDR_W = 8;
    localparam int DUR_W = 6;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_SHOCK_HY_DUR = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_THRESHOLDS = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_FF_HY_DUR = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_AXIS_SWAP = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_ORIENT_BLOCK = 8'h0a;
    localparam logic [ADDR_W-1:0] ADDR_ORIENT_STATUS = 8'h0b;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_ORIENT_EN = 8'h0d;
    localparam logic [ADDR_W-1:0] ADDR_FF_SHOCK_EN = 8'h0e;
    localparam logic [ADDR_W-1:0] ADDR_SHOCK_DETAIL = 8'h0f;
    localparam logic [ADDR_W-1:0] ADDR_DATA_READY = 8'h10;

    // field positions
    localparam int POS_AXIS_SWAP = 7;
    localparam int POS_ORIENT_FLAG = 7;
    localparam int POS_ORIENT_CODE = 4;
    localparam int POS_FF_FLAG = 3;
    localparam int POS_SHOCK_FLAG = 2;
    localparam int POS_ORIENT_EN = 6;
    localparam int POS_FF_EN = 3;
    localparam int POS_SHOCK_SIGN = 3;
    localparam int POS_DR_EN = 0;
    localparam int POS_DR_FLAG = 1;

    // values after reset
    localparam logic [3:0] RST_FF_TH = 4'h4;
    localparam logic [1:0] RST_FF_HY = 2'h1;
    localparam logic [5:0] RST_FF_DUR = 6'h3f;
    localparam logic [3:0] RST_SHOCK_TH = 4'he;
    localparam logic [1:0] RST_SHOCK_HY = 2'h1;
    localparam logic [5:0] RST_SHOCK_DUR = 6'h3f;
    localparam logic [1:0] RST_BLOCK = 2'h2;
    localparam logic [2:0] RST_ORIENT = 3'h0;

    // acceleration scale: counts per g
    localparam int ONE_G = 32;
    localparam logic [ACC_W:0] Z_BLOCK_LVL = 9'(ONE_G * 9 / 10);
    localparam logic [ACC_W:0] XY_BLOCK_LVL = 9'(ONE_G * 4 / 10);
    localparam logic [ACC_W:0] UPDN_HYS_LVL = 9'(ONE_G * 4 / 10);
    localparam logic [ACC_W:0] SLOPE_LVL_1 = 9'(ONE_G * 2 / 10);
    localparam logic [ACC_W:0] SLOPE_LVL_2 = 9'(ONE_G * 3 / 10);
    localparam logic [ACC_W:0] SLOPE_LVL_3 = 9'(ONE_G * 4 / 10);
    localparam logic [15:0] RATIO_DEN = 16'd100;
    localparam logic [15:0] RATIO_LO = 16'd66;
    localparam logic [15:0] RATIO_HI = 16'd166;
    localparam logic [1:0] SLOPE_QUIET_N = 2'd3;

    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int ORIENT_WAIT_MS = 100;
    localparam int ORIENT_WAIT_CYC = CLK_HZ / 1000 * ORIENT_WAIT_MS;
    localparam int DR_HOLD_US = 150;
    localparam int DR_HOLD_CYC = CLK_HZ / 1_000_000 * DR_HOLD_US;
    localparam int DR_CNT_W = 12;

endpackage : medet_pkg

// [src/medet_dur_counter.sv]
// duration counter: condition held for one more than the programmed number of samples
`timescale 1ns/1ps
`default_nettype none
module medet_dur_counter
    import medet_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // sample strobe and conditions
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             start_cond,
    input  wire logic             hold_cond,
    input  wire logic [DUR_W-1:0] dur,
    // result
    output logic                  fire
);
    logic           run;
    logic           done;
    logic [DUR_W:0] cnt;
    logic [DUR_W:0] next_cnt;
    logic           cond;

    // entry needs the tight level, staying only the hysteresis level
    assign cond     = run ? hold_cond : start_cond;
    assign next_cnt = run ? cnt + 1'b1 : (DUR_W+1)'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run  <= 1'b0;
            done <= 1'b0;
            cnt  <= '0;
            fire <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (!enable) begin
                run  <= 1'b0;
                done <= 1'b0;
                cnt  <= '0;
            end else if (tick) begin
                if (!cond) begin
                    run  <= 1'b0;
                    done <= 1'b0;
                    cnt  <= '0;
                end else begin
                    run <= 1'b1;
                    // saturate so a long event cannot wrap and fire twice
                    if (!done) begin
                        cnt <= next_cnt;
                    end
                    if (!done && next_cnt == {1'b0, dur} + 1'b1) begin
                        fire <= 1'b1;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : medet_dur_counter
`default_nettype wire

// [src/medet_top.sv]
// motion event detectors: orientation, freefall, high-g and data ready
`timescale 1ns/1ps
`default_nettype none
module medet_top
    import medet_pkg::*;
#(
    parameter int ORIENT_WAIT = ORIENT_WAIT_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // acceleration samples and update strobes
    input  wire logic signed [ACC_W-1:0] acc_x,
    input  wire logic signed [ACC_W-1:0] acc_y,
    input  wire logic signed [ACC_W-1:0] acc_z,
    input  wire logic [2:0]              data_update,
    input  wire logic [2:0]              chan_en,
    // operating mode
    input  wire logic                    standalone,
    // register port
    input  wire logic [ADDR_W-1:0]       reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [7:0]                   reg_rdata,
    // interrupt and orientation pins
    output logic                         int_out,
    output logic [2:0]                   orient_pin
);
    import medet_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [3:0]       ff_th;
    logic [1:0]       ff_hy;
    logic [DUR_W-1:0] ff_dur;
    logic [3:0]       sh_th;
    logic [1:0]       sh_hy;
    logic [DUR_W-1:0] sh_dur;
    logic             axis_swap_select;
    logic [1:0]       blk_mode;
    logic             en_orient;
    logic             en_ff;
    logic [2:0]       en_sh;
    logic             en_dr;
    logic             wr_ok;

    // configuration is frozen at its current values in stand-alone mode
    assign wr_ok = reg_wr && !standalone;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ff_th            <= RST_FF_TH;
            ff_hy            <= RST_FF_HY;
            ff_dur           <= RST_FF_DUR;
            sh_th            <= RST_SHOCK_TH;
            sh_hy            <= RST_SHOCK_HY;
            sh_dur           <= RST_SHOCK_DUR;
            axis_swap_select <= 1'b0;
            blk_mode         <= RST_BLOCK;
            en_orient        <= 1'b0;
            en_ff            <= 1'b0;
            en_sh            <= 3'h0;
            en_dr            <= 1'b0;
        end else if (wr_ok) begin
            case (reg_addr)
                ADDR_SHOCK_HY_DUR: begin
                    sh_hy  <= reg_wdata[7:6];
                    sh_dur <= reg_wdata[5:0];
                end
                ADDR_THRESHOLDS: begin
                    ff_th <= reg_wdata[7:4];
                    sh_th <= reg_wdata[3:0];
                end
                ADDR_FF_HY_DUR: begin
                    ff_hy  <= reg_wdata[7:6];
                    ff_dur <= reg_wdata[5:0];
                end
                ADDR_AXIS_SWAP:    axis_swap_select <= reg_wdata[POS_AXIS_SWAP];
                ADDR_ORIENT_BLOCK: blk_mode <= reg_wdata[1:0];
                ADDR_ORIENT_EN:    en_orient <= reg_wdata[POS_ORIENT_EN];
                ADDR_FF_SHOCK_EN: begin
                    en_ff <= reg_wdata[POS_FF_EN];
                    en_sh <= reg_wdata[2:0];
                end
                ADDR_DATA_READY:   en_dr <= reg_wdata[POS_DR_EN];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample strobe: one tick once every enabled axis has updated
    logic [2:0] upd_seen;
    logic [2:0] upd_all;
    logic       tick;

    assign upd_all = upd_seen | data_update;
    assign tick    = (chan_en != 3'h0) && ((upd_all & chan_en) == chan_en);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_seen <= 3'h0;
        end else if (tick) begin
            upd_seen <= 3'h0;
        end else begin
            upd_seen <= upd_all;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // magnitudes, slopes
    function automatic logic [ACC_W:0] abs_val(input logic signed [ACC_W:0] v);
        abs_val = v[ACC_W] ? (ACC_W+1)'(0) - v : v;
    endfunction : abs_val

    logic signed [ACC_W-1:0] acc   [3];
    logic signed [ACC_W-1:0] prev  [3];
    logic [ACC_W:0]          mag   [3];
    logic [ACC_W:0]          slope [3];
    logic [2:0]              slope_neg;

    assign acc[0] = acc_x;
    assign acc[1] = acc_y;
    assign acc[2] = acc_z;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            logic signed [ACC_W:0] diff;
            assign diff          = (ACC_W+1)'(acc[gi]) - (ACC_W+1)'(prev[gi]);
            assign mag[gi]       = abs_val((ACC_W+1)'(acc[gi]));
            assign slope[gi]     = abs_val(diff);
            assign slope_neg[gi] = diff[ACC_W];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev[gi] <= '0;
                end else if (tick) begin
                    prev[gi] <= acc[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // orientation candidate
    logic signed [ACC_W-1:0] ox;
    logic signed [ACC_W-1:0] oy;
    logic signed [ACC_W-1:0] oz;
    logic [ACC_W:0]          max_slope;
    logic [ACC_W:0]          slope_lvl;
    logic [15:0]             ax16;
    logic [15:0]             ay16;
    logic [ACC_W:0]          az;
    logic [2:0]              orient;
    logic [2:0]              cand;
    logic                    ls_next;
    logic                    low_next;
    logic                    down_next;

    // swapping x and z with y negated keeps the axes right-handed
    assign ox = axis_swap_select ? acc_z : acc_x;
    assign oy = axis_swap_select ? -acc_y : acc_y;
    assign oz = axis_swap_select ? acc_x : acc_z;
    assign ax16 = 16'(abs_val((ACC_W+1)'(ox)));
    assign ay16 = 16'(abs_val((ACC_W+1)'(oy)));
    assign az   = abs_val((ACC_W+1)'(oz));

    // leaving landscape needs ratio below 0.66, entering needs above 1.66
    assign ls_next = orient[1] ? !(ay16 * RATIO_DEN < ax16 * RATIO_LO)
                               : (ay16 * RATIO_DEN > ax16 * RATIO_HI);
    assign low_next  = ls_next ? (oy > 0) : (ox < 0);
    assign down_next = orient[2] ? !(!oz[ACC_W-1] && az > UPDN_HYS_LVL)
                                 : (oz[ACC_W-1] && az > UPDN_HYS_LVL);
    assign cand      = {down_next, ls_next, low_next};

    always_comb begin
        max_slope = slope[0];
        if (slope[1] > max_slope) max_slope = slope[1];
        if (slope[2] > max_slope) max_slope = slope[2];
        case (blk_mode)
            2'h1:    slope_lvl = SLOPE_LVL_1;
            2'h2:    slope_lvl = SLOPE_LVL_2;
            default: slope_lvl = SLOPE_LVL_3;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // orientation blocking and stability timer
    logic        orient_run;
    logic [1:0]  quiet_cnt;
    logic        blocked;
    logic [2:0]  last_cand;
    logic [31:0] wait_cnt;
    logic        wait_expire;
    logic        orient_fire;

    // stand-alone orientation mode runs detection without the enable bit
    assign orient_run = en_orient || standalone;

    assign blocked = (blk_mode != 2'h0) && (az > Z_BLOCK_LVL ||
                     (ax16[ACC_W:0] + ay16[ACC_W:0]) < XY_BLOCK_LVL ||
                     quiet_cnt < SLOPE_QUIET_N);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt <= 2'h0;
        end else if (tick) begin
            if (max_slope > slope_lvl) begin
                quiet_cnt <= 2'h0;
            end else if (quiet_cnt < SLOPE_QUIET_N) begin
                quiet_cnt <= quiet_cnt + 2'h1;
            end
        end
    end

    assign wait_expire = (wait_cnt == 32'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_cand <= RST_ORIENT;
            wait_cnt  <= 32'h0;
        end else begin
            if (tick) begin
                last_cand <= cand;
            end
            if (!orient_run || blk_mode == 2'h0) begin
                wait_cnt <= 32'h0;
            end else if (tick && cand != last_cand) begin
                wait_cnt <= 32'(ORIENT_WAIT);
            end else if (wait_cnt != 32'h0) begin
                wait_cnt <= wait_cnt - 32'h1;
            end
        end
    end

    // the timed candidate commits when the wait expires and nothing blocks
    always_comb begin
        orient_fire = 1'b0;
        if (orient_run) begin
            if (blk_mode == 2'h0) begin
                orient_fire = tick && cand != orient;
            end else begin
                orient_fire = wait_expire && !blocked && last_cand != orient;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            orient <= RST_ORIENT;
        end else if (orient_fire) begin
            orient <= (blk_mode == 2'h0) ? cand : last_cand;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // freefall and high-g engines
    logic [ACC_W:0] ff_lo;
    logic [ACC_W:0] ff_hi;
    logic [ACC_W:0] sh_hi;
    logic [ACC_W:0] sh_lo;
    logic [2:0]     sh_over;
    logic [2:0]     sh_stay;
    logic           ff_fire;
    logic           sh_fire;

    // thresholds count in two acceleration steps
    assign ff_lo = (ACC_W+1)'({ff_th, 1'b0});
    assign ff_hi = (ACC_W+1)'({ff_th, 1'b0}) + (ACC_W+1)'({ff_hy, 1'b0});
    assign sh_hi = (ACC_W+1)'({sh_th, 1'b0});
    assign sh_lo = (ACC_W+1)'({sh_th, 1'b0}) - (ACC_W+1)'({sh_hy, 1'b0});

    generate
        for (gi = 0; gi < 3; gi++) begin : g_shock
            assign sh_over[gi] = en_sh[2-gi] && mag[gi] > sh_hi;
            assign sh_stay[gi] = en_sh[2-gi] && mag[gi] >= sh_lo;
        end
    endgenerate

    medet_dur_counter u_ff (
        .clk        (clk),
        .rst_n      (rst_n),
        .tick       (tick),
        .enable     (en_ff),
        .start_cond (mag[0] < ff_lo && mag[1] < ff_lo && mag[2] < ff_lo),
        .hold_cond  (mag[0] < ff_hi && mag[1] < ff_hi && mag[2] < ff_hi),
        .dur        (ff_dur),
        .fire       (ff_fire)
    );

    medet_dur_counter u_sh (
        .clk        (clk),
        .rst_n      (rst_n),
        .tick       (tick),
        .enable     (en_sh != 3'h0),
        .start_cond (sh_over != 3'h0),
        .hold_cond  (sh_stay != 3'h0),
        .dur        (sh_dur),
        .fire       (sh_fire)
    );

    // detail captured one cycle after the firing sample; prev holds it
    logic [2:0] sh_axes;
    logic       sh_sign;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_axes <= 3'h0;
            sh_sign <= 1'b0;
        end else if (sh_fire) begin
            sh_axes <= {sh_stay[0], sh_stay[1], sh_stay[2]};
            sh_sign <= sh_stay[0] ? prev[0][ACC_W-1] :
                       sh_stay[1] ? prev[1][ACC_W-1] : prev[2][ACC_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags: set wins over clear-on-read
    logic orient_flag;
    logic ff_flag;
    logic sh_flag;
    logic dr_flag;
    logic rd_orient;
    logic rd_events;
    logic rd_dr;

    assign rd_orient = reg_rd && reg_addr == ADDR_ORIENT_STATUS;
    assign rd_events = reg_rd && reg_addr == ADDR_EVENT_FLAGS;
    assign rd_dr     = reg_rd && reg_addr == ADDR_DATA_READY;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            orient_flag <= 1'b0;
            ff_flag     <= 1'b0;
            sh_flag     <= 1'b0;
            dr_flag     <= 1'b0;
        end else begin
            orient_flag <= orient_fire || (orient_flag && !rd_orient);
            ff_flag     <= ff_fire || (ff_flag && !rd_events);
            sh_flag     <= sh_fire || (sh_flag && !rd_events);
            dr_flag     <= (tick && en_dr) || (dr_flag && !rd_dr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt lines: event lines last until the next sample
    logic                orient_line;
    logic                ff_line;
    logic                sh_line;
    logic [DR_CNT_W-1:0] dr_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            orient_line <= 1'b0;
            ff_line     <= 1'b0;
            sh_line     <= 1'b0;
        end else begin
            orient_line <= orient_fire || (orient_line && !tick);
            ff_line     <= ff_fire || (ff_line && !tick);
            sh_line     <= sh_fire || (sh_line && !tick);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_cnt <= '0;
        end else if (tick && en_dr) begin
            dr_cnt <= DR_CNT_W'(DR_HOLD_CYC);
        end else if (dr_cnt != '0) begin
            dr_cnt <= dr_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_out <= 1'b0;
        end else if (en_dr) begin
            int_out <= dr_cnt != '0;
        end else begin
            int_out <= orient_line || ff_line || sh_line;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            orient_pin <= RST_ORIENT;
        end else begin
            orient_pin <= standalone ? orient : RST_ORIENT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_SHOCK_HY_DUR:  reg_rdata <= {sh_hy, sh_dur};
                ADDR_THRESHOLDS:    reg_rdata <= {ff_th, sh_th};
                ADDR_FF_HY_DUR:     reg_rdata <= {ff_hy, ff_dur};
                ADDR_AXIS_SWAP:     reg_rdata <= {axis_swap_select, 7'h00};
                ADDR_ORIENT_BLOCK:  reg_rdata <= {6'h00, blk_mode};
                ADDR_ORIENT_STATUS: reg_rdata <= {orient_flag, orient, 4'h0};
                ADDR_EVENT_FLAGS:   reg_rdata <= {4'h0, ff_flag, sh_flag, 2'h0};
                ADDR_ORIENT_EN:     reg_rdata <= {1'b0, en_orient, 6'h00};
                ADDR_FF_SHOCK_EN:   reg_rdata <= {4'h0, en_ff, en_sh};
                ADDR_SHOCK_DETAIL:  reg_rdata <= {4'h0, sh_sign, sh_axes};
                ADDR_DATA_READY:    reg_rdata <= {6'h00, dr_flag, en_dr};
                default:            reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : medet_top
`default_nettype wire

// [verification/medet_props.sv]
// checker: register readback and orientation pin relations
`timescale 1ns/1ps
`default_nettype none
module medet_props
    import medet_pkg::*;
#(
    parameter int ORIENT_WAIT = ORIENT_WAIT_CYC
) (
    // clock, reset and mode
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              standalone,
    // register port and pins
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic [2:0]        orient_pin
);
    logic [7:0] shd [16];
    // shadow of host writes; its reset load doubles as the default check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shd <= '{5: 8'h7f, 6: 8'h4e, 7: 8'h7f, 10: 8'h02, default: 8'h00};
        end else if (reg_wr && !standalone && reg_addr < 8'h10) begin
            shd[reg_addr[3:0]] <= reg_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pin_idle: assert property (!standalone && !$past(standalone) |->
        orient_pin == 3'h0) else $error("pin not idle");
    // pin and read data both trail the code by one register stage
    a_pin_status: assert property (standalone && $past(standalone) && $past(reg_rd) &&
        $past(reg_addr) == 8'h0b |-> reg_rdata[6:4] == orient_pin) else $error("pin code");
    a_shock_cfg: assert property ($past(reg_rd) && $past(reg_addr) == 8'h05 |->
        reg_rdata == shd[5]) else $error("bad 0x05");
    a_thresh_cfg: assert property ($past(reg_rd) && $past(reg_addr) == 8'h06 |->
        reg_rdata == shd[6]) else $error("bad 0x06");
    a_ff_cfg: assert property ($past(reg_rd) && $past(reg_addr) == 8'h07 |->
        reg_rdata == shd[7]) else $error("bad 0x07");
    a_swap_bit: assert property ($past(reg_rd) && $past(reg_addr) == 8'h09 |->
        reg_rdata[7] == shd[9][7]) else $error("bad swap bit");
    a_orient_en: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0d |->
        reg_rdata[6] == shd[13][6]) else $error("bad orient enable");
    a_ffsh_en: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0e |->
        reg_rdata[3:0] == shd[14][3:0]) else $error("bad event enables");
endmodule : medet_props
bind medet_top medet_props #(.ORIENT_WAIT(ORIENT_WAIT)) props_u (.clk(clk), .rst_n(rst_n),
    .standalone(standalone), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .orient_pin(orient_pin));
`default_nettype wire

// [verification/medet_host.sv]
// host model: register port master
`timescale 1ns/1ps
`default_nettype none
module medet_host (
    // clock and answer
    input wire logic       clk,
    input wire logic [7:0] reg_rdata,
    // requests
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic       reg_wr,
    output var logic       reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // strobe drops at the taking edge, so the next call starts an edge later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : medet_host
`default_nettype wire

// [verification/medet_top_tb.sv]
// testbench: register-port sequences against the motion event detectors
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module medet_top_tb;
    import medet_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              standalone = 1'b0;
    logic [ACC_W-1:0]  ax = '0, ay = '0, az = '0;
    logic [2:0]        upd = '0, pin, chan = 3'h7;
    logic [7:0]        addr, wdata, rdata;
    logic              wr, rd, int_out;
    int                mismatches = 0, num_checks = 0, cyc = 0;
    medet_top #(.ORIENT_WAIT(20)) dut_u (.clk(clk), .rst_n(rst_n), .acc_x(ax), .acc_y(ay),
        .acc_z(az), .data_update(upd), .chan_en(chan), .standalone(standalone),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .int_out(int_out), .orient_pin(pin));
    medet_host host_u (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd));
    initial forever #20 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        `CHK(d, e)
    endtask : rc
    // n ticks of one sample; the gap lets the event engines settle between ticks, but not the orientation wait
    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z, int n);
        repeat (n) begin
            @(posedge clk);
            {ax, ay, az} <= {x, y, z};
            upd <= 3'h7;
            @(posedge clk);
            upd <= 3'h0;
            repeat (4) @(posedge clk);
        end
    endtask : smp
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rc(8'h05, 8'h7f);
        rc(8'h06, 8'h4e);
        rc(8'h07, 8'h7f);
        rc(8'h0a, 8'h02);
        rc(8'h0c, 8'h00);
        rc(8'h20, 8'h00);
        host_u.wr(8'h0a, 8'h00);
        smp(8'he0, 8'h00, 8'h10, 1);
        rc(8'h0b, 8'h00);
        host_u.wr(8'h0d, 8'h40);
        smp(8'he0, 8'h00, 8'h10, 1);
        `CHK(int_out, 1'b1)
        rc(8'h0b, 8'h90);
        rc(8'h0b, 8'h10);
        smp(8'he0, 8'h00, 8'h10, 1);
        `CHK(int_out, 1'b0)
        smp(8'he0, 8'h00, 8'hf0, 1);
        rc(8'h0b, 8'hd0);
        smp(8'h00, 8'h20, 8'hf0, 1);
        rc(8'h0b, 8'hf0);
        host_u.wr(8'h07, 8'h41);
        host_u.wr(8'h0e, 8'h08);
        smp(8'h00, 8'h00, 8'h00, 1);
        rc(8'h0c, 8'h00);
        smp(8'h00, 8'h00, 8'h00, 1);
        rc(8'h0c, 8'h08);
        host_u.wr(8'h05, 8'h41);
        host_u.wr(8'h0e, 8'h04);
        smp(8'h40, 8'h00, 8'h00, 1);
        rc(8'h0c, 8'h00);
        smp(8'h40, 8'h00, 8'h00, 1);
        rc(8'h0c, 8'h04);
        rc(8'h0f, 8'h04);
        host_u.wr(8'h09, 8'h80);
        smp(8'h14, 8'h00, 8'he0, 1);
        rc(8'h0b, 8'h90);
        host_u.wr(8'h10, 8'h01);
        smp(8'h14, 8'h00, 8'h20, 1);
        `CHK(int_out, 1'b1)
        repeat (3760) @(posedge clk);
        `CHK(int_out, 1'b0)
        rc(8'h0b, 8'h80);
        rc(8'h10, 8'h03);
        @(posedge clk);
        {chan, upd} <= {3'h5, 3'h1};
        rc(8'h10, 8'h01);
        @(posedge clk);
        upd <= 3'h4;
        rc(8'h10, 8'h03);
        host_u.wr(8'h10, 8'h00);
        @(posedge clk);
        {rst_n, standalone} <= 2'b01;
        @(posedge clk);
        rst_n <= 1'b1;
        host_u.wr(8'h09, 8'h80);
        rc(8'h09, 8'h00);
        smp(8'h00, 8'h20, 8'h10, 4);
        repeat (30) @(posedge clk);
        `CHK(pin, 3'h3)
        rc(8'h0b, 8'hb0);
        wrap_up();
    end
endmodule : medet_top_tb
`default_nettype wire
